// *** src/ivec_core.sv ***
`timescale 1ns/1ps
// What this block does
// - Push return address before jumping to service routine
// - Vector high from register, low fixed per source
// - Separate internal and external vector high registers
// - Vector registers reached only via accumulator moves
// - Restart ops 10,18,20,28,38 start interrupt sequence
// - Restart ops 00,08,30 are not decoded
// - Restart interrupt taken at any priority level
// - Restart uses internal vector high register
// - Interrupt entry leaves code page register untouched
// - I/O decrementing move writes memory byte to I/O
// - That move decrements both pointer pairs
// - Single move atomic; repeating moves interruptible between iterations
// - I/O word store writes two bytes without interruption
// - Accept only higher priority, after instruction completes
// - Priority stack shifts left two, loads new priority
// - Defer acceptance after a privileged instruction
// - Interrupt return pops priority stack, then address
module ivec_core
	import ivec_pkg::*;
(
	input  wire logic         clock,       // 100 MHz core clock
	input  wire logic         rst_b,       // Asynchronous reset, active low
	input  wire logic         clkEn,       // Freezes all state when low
	input  wire logic         instrDone,   // Pulse: instruction boundary reached
	input  wire ivec_iclass_t instrClass,  // Class of the completed instruction
	input  wire logic [7:0]   rstOp,       // Restart operand
	input  wire logic [15:0]  nextPc,      // Return address of the boundary
	input  wire logic [7:0]   accIn,       // Accumulator value
	input  wire logic [15:0]  srcPtrIn,    // Source pointer pair
	input  wire logic [15:0]  dstPtrIn,    // Destination pointer pair
	input  wire logic [15:0]  ioWordData,  // Word to store to I/O
	input  wire logic [7:0]   codePageIn,  // Current code window page
	input  wire ivec_req_t    hwReq,       // Hardware interrupt request
	input  wire logic         busDone,     // Pulse: bus cycle completed
	input  wire logic [7:0]   busRdData,   // Read data for completed cycle
	output ivec_bus_t         busReq,      // Bus cycle request
	output logic              busy,        // Sequencer owns the core
	output logic              hwAck,       // Pulse: hardware request accepted
	output logic              pcLoad,      // Pulse: load pcValue into PC
	output logic [15:0]       pcValue,     // New program counter
	output logic [7:0]        accOut,      // Accumulator result of vector reads
	output logic              accLoad,     // Pulse: load accOut
	output logic [15:0]       srcPtrOut,   // Updated source pointer pair
	output logic [15:0]       dstPtrOut,   // Updated destination pointer pair
	output logic              ptrLoad,     // Pulse: load both pointer pairs
	output logic              illegalOp,   // Pulse: undecoded restart operand
	output logic [7:0]        codePageOut, // Code window page, passed untouched
	output logic [7:0]        prioStack,   // Priority stack register
	output logic [15:0]       stackPtr     // Stack pointer
);
	ivec_state_t  state_r, state_nxt;
	logic [7:0]   intVecHi_r, intVecHi_nxt;
	logic [7:0]   extVecHi_r, extVecHi_nxt;
	logic [7:0]   prio_r, prio_nxt;
	logic [15:0]  sp_r, sp_nxt;
	logic [15:0]  retAddr_r, retAddr_nxt;
	logic [15:0]  vecAddr_r, vecAddr_nxt;
	logic [15:0]  src_r, src_nxt;
	logic [15:0]  dst_r, dst_nxt;
	logic [7:0]   data_r, data_nxt;
	logic         atomic_r, atomic_nxt;
	ivec_bus_t    bus_r, bus_nxt;
	logic [7:0]   acc_r, acc_nxt;
	logic         accLoad_r, accLoad_nxt;
	logic         ptrLoad_r, ptrLoad_nxt;
	logic         pcLoad_r, pcLoad_nxt;
	logic [15:0]  pc_r, pc_nxt;
	logic         ack_r, ack_nxt;
	logic         ill_r, ill_nxt;
	logic         rstLegal;
	logic         hwTake;

	// Only five restart operands exist; 00, 08 and 30 fall out as illegal
	assign rstLegal = rstOp inside {RST_OP_10, RST_OP_18, RST_OP_20, RST_OP_28,
		RST_OP_38};

	// Hardware acceptance: higher priority, at a boundary, not after a privileged op.
	// A return is privileged too, so its pops always run to the end first.
	assign hwTake = instrDone && hwReq.valid && (hwReq.prio > prio_r[1:0])
		&& instrClass != IC_PRIV && instrClass != IC_IRET
		&& instrClass != IC_RST && !atomic_r;

	// Main sequencer next state
	always_comb begin
		state_nxt    = state_r;
		intVecHi_nxt = intVecHi_r;
		extVecHi_nxt = extVecHi_r;
		prio_nxt     = prio_r;
		sp_nxt       = sp_r;
		retAddr_nxt  = retAddr_r;
		vecAddr_nxt  = vecAddr_r;
		src_nxt      = src_r;
		dst_nxt      = dst_r;
		data_nxt     = data_r;
		atomic_nxt   = atomic_r;
		bus_nxt      = bus_r;
		acc_nxt      = acc_r;
		accLoad_nxt  = 1'b0;
		ptrLoad_nxt  = 1'b0;
		pcLoad_nxt   = 1'b0;
		pc_nxt       = pc_r;
		ack_nxt      = 1'b0;
		ill_nxt      = 1'b0;
		unique case (state_r)
			ST_IDLE: begin
				if (instrDone) begin
					atomic_nxt   = 1'b0;
					if (hwTake) begin
						// Shift the priority stack and push the accepted level
						prio_nxt = {prio_r[5:0], hwReq.prio};
						vecAddr_nxt = {hwReq.extSrc ? extVecHi_r : intVecHi_r,
							hwReq.lowByte};
						retAddr_nxt = nextPc;
						ack_nxt     = 1'b1;
						state_nxt   = ST_PUSHH;
					end else begin
						unique case (instrClass)
							IC_RST: begin
								if (rstLegal) begin
									// No priority test: taken even at level 3
									vecAddr_nxt = {intVecHi_r, rstOp};
									retAddr_nxt = nextPc;
									state_nxt   = ST_PUSHH;
								end else begin
									ill_nxt = 1'b1;
								end
							end
							IC_LDIO_DEC: begin
								src_nxt   = srcPtrIn;
								dst_nxt   = dstPtrIn;
								atomic_nxt = 1'b1;
								bus_nxt   = '{valid: 1'b1, write: 1'b0, io: 1'b0,
									addr: srcPtrIn, data: 8'h00};
								state_nxt = ST_MVRD;
							end
							IC_LDI: atomic_nxt = 1'b1;
							IC_RPT_INC, IC_RPT_DEC: atomic_nxt = 1'b0;
							IC_IOWORD: begin
								atomic_nxt = 1'b1;
								bus_nxt = '{valid: 1'b1, write: 1'b1, io: 1'b1,
									addr: dstPtrIn, data: ioWordData[7:0]};
								dst_nxt   = dstPtrIn;
								data_nxt  = ioWordData[15:8];
								state_nxt = ST_IOW0;
							end
							IC_RD_INT, IC_RD_EXT: begin
								acc_nxt = (instrClass == IC_RD_EXT) ? extVecHi_r
									: intVecHi_r;
								accLoad_nxt = 1'b1;
							end
							IC_WR_INT: intVecHi_nxt = accIn;
							IC_WR_EXT: extVecHi_nxt = accIn;
							IC_IRET: begin
								bus_nxt = '{valid: 1'b1, write: 1'b0, io: 1'b0,
									addr: sp_r, data: 8'h00};
								state_nxt = ST_POPIP;
							end
							default: ;
						endcase
					end
				end
			end
			ST_PUSHH, ST_PUSHL: begin
				// High byte of return address first, then low; the stack grows down
				bus_nxt = '{valid: 1'b1, write: 1'b1, io: 1'b0, addr: sp_r - 16'h0001,
					data: (state_r == ST_PUSHH) ? retAddr_r[15:8] : retAddr_r[7:0]};
				if (busDone) begin
					sp_nxt        = sp_r - 16'h0001;
					bus_nxt.valid = (state_r == ST_PUSHH);
					state_nxt     = (state_r == ST_PUSHH) ? ST_PUSHL : ST_JUMP;
				end
			end
			ST_JUMP: begin
				// Code page is never written here, so routines live in root space
				pc_nxt     = vecAddr_r;
				pcLoad_nxt = 1'b1;
				state_nxt  = ST_IDLE;
			end
			ST_MVRD: if (busDone) begin
				bus_nxt = '{valid: 1'b1, write: 1'b1, io: 1'b1,
					addr: dst_r, data: busRdData};
				state_nxt = ST_MVWR;
			end
			ST_MVWR: if (busDone) begin
				bus_nxt.valid = 1'b0;
				src_nxt     = src_r - 16'h0001;
				dst_nxt     = dst_r - 16'h0001;
				ptrLoad_nxt = 1'b1;
				state_nxt   = ST_IDLE;
			end
			ST_IOW0: if (busDone) begin
				bus_nxt = '{valid: 1'b1, write: 1'b1, io: 1'b1,
					addr: dst_r + 16'h0001, data: data_r};
				state_nxt = ST_IOW1;
			end
			ST_IOW1: if (busDone) begin
				bus_nxt.valid = 1'b0;
				state_nxt = ST_IDLE;
			end
			ST_POPIP: if (busDone) begin
				prio_nxt = busRdData;
				sp_nxt   = sp_r + 16'h0001;
				bus_nxt  = '{valid: 1'b1, write: 1'b0, io: 1'b0,
					addr: sp_r + 16'h0001, data: 8'h00};
				state_nxt = ST_POPL;
			end
			ST_POPL: if (busDone) begin
				pc_nxt   = {pc_r[15:8], busRdData};
				sp_nxt   = sp_r + 16'h0001;
				bus_nxt.addr = sp_r + 16'h0001;
				state_nxt = ST_POPH;
			end
			ST_POPH: if (busDone) begin
				pc_nxt   = {busRdData, pc_r[7:0]};
				sp_nxt   = sp_r + 16'h0001;
				bus_nxt.valid = 1'b0;
				state_nxt = ST_RETJMP;
			end
			ST_RETJMP: begin
				pcLoad_nxt = 1'b1;
				state_nxt  = ST_IDLE;
			end
			default: state_nxt = ST_IDLE;
		endcase
	end

	// State registers; clkEn freezes everything
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			state_r    <= ST_IDLE;
			intVecHi_r <= VEC_HI_RESET;
			extVecHi_r <= VEC_HI_RESET;
			prio_r     <= PRIO_STACK_RESET;
			sp_r       <= SP_RESET;
			retAddr_r  <= 16'h0000;
			vecAddr_r  <= 16'h0000;
			src_r      <= 16'h0000;
			dst_r      <= 16'h0000;
			data_r     <= 8'h00;
			atomic_r   <= 1'b0;
			bus_r      <= '0;
			acc_r      <= 8'h00;
			accLoad_r  <= 1'b0;
			ptrLoad_r  <= 1'b0;
			pcLoad_r   <= 1'b0;
			pc_r       <= 16'h0000;
			ack_r      <= 1'b0;
			ill_r      <= 1'b0;
		end else if (clkEn) begin
			state_r    <= state_nxt;
			intVecHi_r <= intVecHi_nxt;
			extVecHi_r <= extVecHi_nxt;
			prio_r     <= prio_nxt;
			sp_r       <= sp_nxt;
			retAddr_r  <= retAddr_nxt;
			vecAddr_r  <= vecAddr_nxt;
			src_r      <= src_nxt;
			dst_r      <= dst_nxt;
			data_r     <= data_nxt;
			atomic_r   <= atomic_nxt;
			bus_r      <= bus_nxt;
			acc_r      <= acc_nxt;
			accLoad_r  <= accLoad_nxt;
			ptrLoad_r  <= ptrLoad_nxt;
			pcLoad_r   <= pcLoad_nxt;
			pc_r       <= pc_nxt;
			ack_r      <= ack_nxt;
			ill_r      <= ill_nxt;
		end
	end

	// Outputs straight from flip-flops, except busy (decoded from state_r) and codePageOut (wired from codePageIn)
	assign busReq      = bus_r;
	assign busy        = (state_r != ST_IDLE);
	assign hwAck       = ack_r;
	assign pcLoad      = pcLoad_r;
	assign pcValue     = pc_r;
	assign accOut      = acc_r;
	assign accLoad     = accLoad_r;
	assign srcPtrOut   = src_r;
	assign dstPtrOut   = dst_r;
	assign ptrLoad     = ptrLoad_r;
	assign illegalOp   = ill_r;
	assign codePageOut = codePageIn;
	assign prioStack   = prio_r;
	assign stackPtr    = sp_r;

	default clocking @(posedge clock); endclocking
	default disable iff (!rst_b);

	sequence s_pushDone;
		clkEn && state_r == ST_PUSHL && busDone;
	endsequence
	property p_pushThenJump;
		s_pushDone |=> state_r == ST_JUMP;
	endproperty
	a_pushThenJump: assert property (p_pushThenJump) else $error("jump not after push");
	property p_accept;
		clkEn && state_r == ST_IDLE && hwTake |=> hwAck && state_r == ST_PUSHH
			&& prioStack == {$past(prio_r[5:0]), $past(hwReq.prio)};
	endproperty
	a_accept: assert property (p_accept) else $error("bad priority push");
	property p_noLowPrio;
		hwAck |-> $past(hwReq.prio) > $past(prio_r[1:0]);
	endproperty
	a_noLowPrio: assert property (p_noLowPrio) else $error("low priority taken");
	property p_rstVec;
		clkEn && state_r == ST_IDLE && instrDone && instrClass == IC_RST && rstLegal
			&& !hwTake |=> state_r == ST_PUSHH && vecAddr_r == {intVecHi_r, $past(rstOp)};
	endproperty
	a_rstVec: assert property (p_rstVec) else $error("restart vector wrong");
	property p_badRst;
		clkEn && state_r == ST_IDLE && instrDone && instrClass == IC_RST && !rstLegal
			&& !hwTake |=> illegalOp && state_r == ST_IDLE;
	endproperty
	a_badRst: assert property (p_badRst) else $error("removed restart ran");
	property p_privDefer;
		clkEn && state_r == ST_IDLE && instrDone
			&& (instrClass == IC_PRIV || instrClass == IC_IRET) |=> !hwAck;
	endproperty
	a_privDefer: assert property (p_privDefer) else $error("taken after privileged");
	property p_moveDec;
		clkEn && state_r == ST_MVWR && busDone |=> ptrLoad
			&& srcPtrOut == $past(src_r) - 16'h0001 && dstPtrOut == $past(dst_r) - 16'h0001;
	endproperty
	a_moveDec: assert property (p_moveDec) else $error("pointers not decremented");
	property p_ioWord;
		clkEn && state_r == ST_IOW0 && busDone |=> busReq.io && busReq.write
			&& busReq.addr == $past(dst_r) + 16'h0001;
	endproperty
	a_ioWord: assert property (p_ioWord) else $error("second byte wrong");
	property p_retOrder;
		clkEn && state_r == ST_POPIP && busDone |=> prioStack == $past(busRdData)
			&& state_r == ST_POPL;
	endproperty
	a_retOrder: assert property (p_retOrder) else $error("return pop order wrong");
endmodule

// *** src/ivec_pkg.sv ***
package ivec_pkg;
	// Instruction-class codes as presented by the decoder at an instruction boundary
	typedef enum logic [3:0] {
		IC_PLAIN    = 4'h0, // Ordinary non-privileged instruction
		IC_PRIV     = 4'h1, // Privileged instruction, defers acceptance
		IC_RST      = 4'h2, // Restart instruction, operand on rstOp
		IC_LDIO_DEC = 4'h3, // I/O-prefixed single decrementing block move
		IC_LDI      = 4'h4, // Single incrementing block move
		IC_RPT_INC  = 4'h5, // Repeating incrementing block move iteration
		IC_RPT_DEC  = 4'h6, // Repeating decrementing block move iteration
		IC_IOWORD   = 4'h7, // Word store to I/O space
		IC_RD_INT   = 4'h8, // Accumulator <- internal vector high byte
		IC_WR_INT   = 4'h9, // Internal vector high byte <- accumulator
		IC_RD_EXT   = 4'hA, // Accumulator <- external vector high byte
		IC_WR_EXT   = 4'hB, // External vector high byte <- accumulator
		IC_IRET     = 4'hC  // Interrupt return
	} ivec_iclass_t;

	// Sequencer states
	typedef enum logic [3:0] {
		ST_IDLE   = 4'b0000,
		ST_PUSHH  = 4'b0001,
		ST_PUSHL  = 4'b0010,
		ST_JUMP   = 4'b0011,
		ST_MVRD   = 4'b0100,
		ST_MVWR   = 4'b0101,
		ST_IOW0   = 4'b0110,
		ST_IOW1   = 4'b0111,
		ST_POPIP  = 4'b1000,
		ST_POPL   = 4'b1001,
		ST_POPH   = 4'b1010,
		ST_RETJMP = 4'b1011
	} ivec_state_t;

	// Hardware interrupt request from the priority/request logic
	typedef struct packed {
		logic       valid;   // Request pending
		logic       extSrc;  // 1: external source, 0: internal
		logic [1:0] prio;    // Requested priority 1..3
		logic [7:0] lowByte; // Source-fixed low address byte
	} ivec_req_t;

	// Bus cycle request towards memory / I/O
	typedef struct packed {
		logic        valid;
		logic        write;
		logic        io;
		logic [15:0] addr;
		logic [7:0]  data;
	} ivec_bus_t;

	localparam logic [7:0] RST_OP_10 = 8'h10;
	localparam logic [7:0] RST_OP_18 = 8'h18;
	localparam logic [7:0] RST_OP_20 = 8'h20;
	localparam logic [7:0] RST_OP_28 = 8'h28;
	localparam logic [7:0] RST_OP_38 = 8'h38;
	localparam logic [7:0] VEC_HI_RESET = 8'h00;
	localparam logic [7:0] PRIO_STACK_RESET = 8'h00;
	localparam logic [15:0] SP_RESET = 16'h0000;
	localparam logic [1:0] PRIO_SUPPRESS_ALL = 2'h3;
	localparam int PRIO_SHIFT = 2;
endpackage

// *** tb/interrupt_vectoring_atomicity_tb.sv ***
`timescale 1ns/1ps
module interrupt_vectoring_atomicity_tb import ivec_pkg::*; ;
	logic         clock, busDone, busy, hwAck, pcLoad, accLoad, ptrLoad, illegalOp;
	logic         rst_b = 1'b0;
	logic         clkEn = 1'b1;
	logic         instrDone = 1'b0;
	ivec_iclass_t instrClass = IC_PLAIN;
	ivec_req_t    hwReq = '0;
	ivec_bus_t    busReq;
	logic [7:0]   rstOp = 8'h00;
	logic [7:0]   accIn = 8'h00;
	logic [7:0]   codePageIn = 8'h00;
	logic [15:0]  nextPc = 16'h0000;
	logic [15:0]  srcPtrIn = 16'h0000;
	logic [15:0]  dstPtrIn = 16'h0000;
	logic [15:0]  ioWordData = 16'h0000;
	logic [7:0]   busRdData, accOut, codePageOut, prioStack;
	logic [15:0]  pcValue, srcPtrOut, dstPtrOut, stackPtr;
	logic [15:0]  seed = 16'h8D5C;
	logic [15:0]  sp = 16'h0000;
	logic [15:0]  lastRet = 16'h0000;
	logic [15:0]  prevRet = 16'h0000;
	logic [39:0]  expQ[$];
	logic [7:0]   rstOk[5] = '{RST_OP_10, RST_OP_18, RST_OP_20, RST_OP_28, RST_OP_38};
	logic [7:0]   rstBad[3] = '{8'h00, 8'h08, 8'h30};
	int           n_fail = 0;
	int           n_compared = 0;
	int           cycles = 0;

	ivec_core i_ivec_core (.clock(clock), .rst_b(rst_b), .clkEn(clkEn), .instrDone(instrDone),
		.instrClass(instrClass), .rstOp(rstOp), .nextPc(nextPc), .accIn(accIn),
		.srcPtrIn(srcPtrIn), .dstPtrIn(dstPtrIn), .ioWordData(ioWordData),
		.codePageIn(codePageIn), .hwReq(hwReq), .busDone(busDone), .busRdData(busRdData),
		.busReq(busReq), .busy(busy), .hwAck(hwAck), .pcLoad(pcLoad), .pcValue(pcValue),
		.accOut(accOut), .accLoad(accLoad), .srcPtrOut(srcPtrOut), .dstPtrOut(dstPtrOut),
		.ptrLoad(ptrLoad), .illegalOp(illegalOp), .codePageOut(codePageOut),
		.prioStack(prioStack), .stackPtr(stackPtr));

	ivec_bus_model i_ivec_bus_model (.clock(clock), .rst_b(rst_b), .busReq(busReq),
		.busDone(busDone), .busRdData(busRdData));

	// 100 MHz clock
	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end

	function automatic logic [15:0] rnd();
		seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
		return seed;
	endfunction

	task automatic report_and_stop();
		$display("compared %0d, failed %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	task automatic fail(input logic [39:0] got, input logic [39:0] exp);
		n_fail++;
		$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
	endtask

	// An event with no note waiting meets an impossible value and fails
	task automatic checkEvt(input logic [39:0] got);
		logic [39:0] exp;
		n_compared++;
		exp = (expQ.size() > 0) ? expQ.pop_front() : 40'hFF_FFFF_FFFF;
		if (got !== exp) fail(got, exp);
	endtask

	task automatic checkVal(input logic [15:0] got, input logic [15:0] exp);
		n_compared++;
		if (got !== exp) fail({24'h00_0000, got}, {24'h00_0000, exp});
	endtask

	task automatic note(input logic [2:0] k, input logic [36:0] d);
		expQ.push_back({k, d});
	endtask

	// Stack pre-decrements: high byte first, then low, then the jump
	task automatic expIrq(input logic [15:0] ret, input logic [15:0] vec);
		note(3'd1, {12'h000, 1'b0, sp - 16'h0001, ret[15:8]});
		note(3'd1, {12'h000, 1'b0, sp - 16'h0002, ret[7:0]});
		note(3'd2, {21'h00_0000, vec});
		sp = sp - 16'h0002;
		prevRet = lastRet;
		lastRet = ret;
	endtask

	// One boundary; rq is {valid, extSrc, prio}, tk says whether entry is expected
	task automatic doInstr(input ivec_iclass_t c, input logic [7:0] op, input logic [3:0] rq,
			input logic tk, input logic [7:0] vhi);
		int k;
		logic [7:0] low;
		@(negedge clock);
		instrClass = c;
		rstOp = op;
		nextPc = rnd();
		codePageIn = 8'(rnd());
		low = 8'(rnd());
		hwReq = {rq, low};
		if (tk && c != IC_RST) note(3'd6, 37'h00_0000_0000);
		if (tk) expIrq(nextPc, {vhi, (c == IC_RST) ? op : low});
		instrDone = 1'b1;
		@(negedge clock);
		instrDone = 1'b0;
		for (k = 0; k < 60 && busy === 1'b1; k++) @(negedge clock);
		hwReq = '0;
		repeat (2) @(negedge clock);
		checkVal({8'h00, codePageOut}, {8'h00, codePageIn});
	endtask

	// Watch the outputs; pulses are sampled in the cycle they stand
	always @(posedge clock) begin
		if (rst_b) begin
			if (busReq.valid && busReq.write && busDone)
				checkEvt({3'd1, 12'h000, busReq.io, busReq.addr, busReq.data});
			if (pcLoad) checkEvt({3'd2, 21'h00_0000, pcValue});
			if (accLoad) checkEvt({3'd3, 29'h0000_0000, accOut});
			if (ptrLoad) checkEvt({3'd4, 5'h00, srcPtrOut, dstPtrOut});
			if (illegalOp) checkEvt({3'd5, 37'h00_0000_0000});
			if (hwAck) checkEvt({3'd6, 37'h00_0000_0000});
		end
	end

	// Hang guard, far above the few hundred cycles the run needs
	always @(posedge clock) begin
		cycles++;
		if (cycles == 5000) begin
			n_fail++;
			report_and_stop();
		end
	end

	initial begin
		repeat (2) @(negedge clock);
		rst_b = 1'b1;
		accIn = 8'h5A;
		doInstr(IC_WR_INT, 8'h00, 4'h0, 1'b0, 8'h00);
		accIn = 8'hC3;
		doInstr(IC_WR_EXT, 8'h00, 4'h0, 1'b0, 8'h00);
		note(3'd3, 37'h00_0000_005A);
		doInstr(IC_RD_INT, 8'h00, 4'h0, 1'b0, 8'h00);
		note(3'd3, 37'h00_0000_00C3);
		doInstr(IC_RD_EXT, 8'h00, 4'h0, 1'b0, 8'h00);
		// A boundary while the clock enable is low must leave the register alone
		clkEn = 1'b0;
		accIn = 8'h11;
		doInstr(IC_WR_INT, 8'h00, 4'h0, 1'b0, 8'h00);
		clkEn = 1'b1;
		note(3'd3, 37'h00_0000_005A);
		doInstr(IC_RD_INT, 8'h00, 4'h0, 1'b0, 8'h00);
		$display("test vector registers done");
		doInstr(IC_PLAIN, 8'h00, 4'h9, 1'b1, 8'h5A);
		checkVal({8'h00, prioStack}, 16'h0001);
		doInstr(IC_PLAIN, 8'h00, 4'h9, 1'b0, 8'h00);
		doInstr(IC_PRIV, 8'h00, 4'hE, 1'b0, 8'h00);
		doInstr(IC_PLAIN, 8'h00, 4'hE, 1'b1, 8'hC3);
		checkVal({8'h00, prioStack}, 16'h0006);
		checkVal(stackPtr, sp);
		$display("test hardware entry done");
		srcPtrIn = rnd() & 16'h7FFF;
		dstPtrIn = rnd();
		note(3'd1, {12'h000, 1'b1, dstPtrIn, srcPtrIn[7:0] ^ 8'hA5});
		note(3'd4, {5'h00, srcPtrIn - 16'h0001, dstPtrIn - 16'h0001});
		doInstr(IC_LDIO_DEC, 8'h00, 4'h0, 1'b0, 8'h00);
		doInstr(IC_PLAIN, 8'h00, 4'hB, 1'b0, 8'h00);
		ioWordData = rnd();
		note(3'd1, {12'h000, 1'b1, dstPtrIn, ioWordData[7:0]});
		note(3'd1, {12'h000, 1'b1, dstPtrIn + 16'h0001, ioWordData[15:8]});
		doInstr(IC_IOWORD, 8'h00, 4'h0, 1'b0, 8'h00);
		doInstr(IC_PLAIN, 8'h00, 4'hB, 1'b0, 8'h00);
		doInstr(IC_RPT_DEC, 8'h00, 4'hB, 1'b1, 8'h5A);
		checkVal({8'h00, prioStack}, 16'h001B);
		$display("test atomic moves done");
		doInstr(IC_PLAIN, 8'h00, 4'hF, 1'b0, 8'h00);
		foreach (rstOk[i]) doInstr(IC_RST, rstOk[i], 4'h0, 1'b1, 8'h5A);
		foreach (rstBad[i]) begin
			note(3'd5, 37'h00_0000_0000);
			doInstr(IC_RST, rstBad[i], 4'h0, 1'b0, 8'h00);
		end
		checkVal(stackPtr, sp);
		checkVal(16'(expQ.size()), 16'h0000);
		$display("test restart instructions done");
		// Return pops priority at SP, then low and high address bytes above it
		note(3'd2, {21'h00_0000, prevRet[7:0], lastRet[15:8]});
		doInstr(IC_IRET, 8'h00, 4'h0, 1'b0, 8'h00);
		sp = sp + 16'h0003;
		checkVal({8'h00, prioStack}, {8'h00, lastRet[7:0]});
		checkVal(stackPtr, sp);
		checkVal(16'(expQ.size()), 16'h0000);
		$display("test interrupt return done");
		report_and_stop();
	end
endmodule

// *** tb/ivec_bus_model.sv ***
`timescale 1ns/1ps
module ivec_bus_model
	import ivec_pkg::*;
(
	input  wire logic      clock,    // Core clock
	input  wire logic      rst_b,    // Reset, active low
	input  wire ivec_bus_t busReq,   // Cycle request from the core
	output logic           busDone,  // Pulse: cycle completed
	output logic [7:0]     busRdData // Read data, valid with busDone
);
	logic [7:0]  mem[logic [16:0]];
	logic [16:0] key;
	logic [1:0]  waitCnt = 2'h0;
	logic [1:0]  slowSel = 2'h0;

	// Memory and I/O share one store, told apart by the io flag
	assign key = {busReq.io, busReq.addr};
	initial begin
		busDone = 1'b0;
		busRdData = 8'h00;
	end
	// Answer after 0..3 idle cycles so prompt and slow paths both run
	always @(negedge clock) begin
		if (busDone || !rst_b || !busReq.valid) begin
			busDone <= 1'b0;
			waitCnt <= 2'h0;
			busRdData <= ~busRdData; // Toggles so a stale byte never passes
		end else if (waitCnt == slowSel) begin
			busDone <= 1'b1;
			slowSel <= slowSel + 2'h1;
			if (busReq.write) mem[key] = busReq.data;
			else busRdData <= mem.exists(key) ? mem[key] : busReq.addr[7:0] ^ 8'hA5;
		end else begin
			waitCnt <= waitCnt + 2'h1;
		end
	end
endmodule
